/* secure_mode_fault_control.sv */
// security supervisor: alarm routing, reset cause, cpu modes, stack
// limits, fuse latch and security row access control
// assumes a cpu register port on clk_sys and sensor pins from outside
//
// Design decisions made here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ns
`include "smfc_map.svh"
module secure_mode_fault_control #(
  parameter int NFAULT = 5
) (
  input  wire logic               clk_sys,
  input  wire logic               reset_n,
  input  wire logic [3:0]         sensor_pin,
  input  wire logic               rom_parity_err,
  input  wire logic [NFAULT-1:0]  fault_detect,
  input  wire logic               ee_light_a,
  input  wire logic               ee_light_b,
  input  wire logic               sp_load,
  input  wire logic [7:0]         sp_value,
  input  wire logic               sys_call,
  input  wire logic               cfg_call,
  input  wire logic               ee_wr_seq,
  input  wire logic               hv_ok,
  input  wire logic [11:0]        ee_code,
  input  wire logic               ee_code_valid,
  input  wire logic               fuse_aes_en,
  input  wire logic               fuse_delivered,
  input  wire logic               test_req,
  input  wire logic [7:0]         addr,
  input  wire logic [7:0]         wdata,
  input  wire logic               wr,
  input  wire logic               rd,
  output logic      [7:0]         rdata,
  output logic                    force_reset,
  output logic                    exc_req,
  output smfc_pkg::exc_code_t     exc_reason,
  output smfc_pkg::cpu_mode_t     cpu_mode,
  output logic                    sensors_enable,
  output logic                    aes_enable,
  output logic      [7:0]         ee_data,
  output logic                    ee_data_valid
);
  import smfc_pkg::*;

  // ************************************************
  // functions
  // ************************************************
  // single error correction of a 12-bit hamming codeword
  function automatic logic [7:0] sec_fix(input logic [11:0] cw);
    logic [3:0]  syn;
    logic [11:0] c;
    syn = 4'h0;
    c = cw;
    for (int i = 0; i < 12; i++) begin
      if (cw[i]) begin
        syn = syn ^ 4'(i + 1);
      end
    end
    if (syn != 4'h0 && syn <= 4'hc) begin
      c[syn - 4'h1] = ~c[syn - 4'h1];
    end
    return {c[11], c[10], c[9], c[8], c[6], c[5], c[4], c[2]};
  endfunction

  // area of a security row byte
  function automatic area_t area_of(input logic [6:0] idx);
    if (idx < `ROW_RO_END) return area_ro;
    if (idx < `ROW_WP_END) return area_wp;
    if (idx < `ROW_WO_END) return area_wo;
    return area_cfg;
  endfunction

  // ************************************************
  // state
  // ************************************************
  logic [3:0]  s1, s2, s3;          // sensor synchronisers
  logic [3:0]  sens_q;              // filtered sensor alarms
  logic [4:0]  force_cnt;           // forced reset length
  logic [5:0]  reset_cause;         // rom, light, temp, freq, volt, ext
  seq_t        seq;                 // boot sequencer
  logic [2:0]  boot_cnt;            // boot phase timer
  ssm_kind_t   kind;                // which super mode applies
  logic        ssm;                 // super_system_flag
  logic        sm;                  // system_flag
  logic [1:0]  light_sel;           // eeprom light detector choice
  logic        hv_valid;            // a write sequence was checked
  logic        hv_pass;             // last check result
  logic        wp_lock;             // protected area locked
  logic        fuse_aes;            // latched fuse values
  logic        fuse_deliv;
  logic        test_fuse;
  logic [7:0]  sp [3];              // per-mode stack pointers
  logic [7:0]  lim [3];             // per-mode stack limits
  logic [7:0]  row_mem [128];       // security row

  // ************************************************
  // decode
  // ************************************************
  wire        rst_i      = !reset_n || (force_cnt != 5'h0);
  wire        sensors_on = (seq != seq_test);
  wire        reset_alarm = (|sens_q && sensors_on) || rom_parity_err;
  wire        reset_fire = reset_alarm && (force_cnt == 5'h0);
  wire [4:0]  next_force = (force_cnt != 5'h0) ? force_cnt - 5'h1 :
                           reset_fire ? 5'(`FORCE_CYC) : 5'h0;
  wire [1:0]  cur_idx    = ssm ? 2'h2 : sm ? 2'h1 : 2'h0;
  wire        in_test    = (seq == seq_test);
  wire        test_avail = test_fuse && !fuse_deliv;
  wire        psw_wr     = wr && (addr == `REG_PSW);
  wire        light_hit  = (light_sel == `LSEL_A && ee_light_a) ||
                           (light_sel == `LSEL_B && ee_light_b);
  wire        fault_hit  = |fault_detect;
  wire        stack_hit  = sp_load && (sp_value >= lim[cur_idx]);
  wire        exc_fire   = (fault_hit || light_hit || stack_hit) && !reset_fire;
  wire        next_ssm   = cfg_call || (ssm && !(psw_wr && !wdata[`PSW_SSM]));
  wire        next_sm    = sys_call || exc_fire ||
                           (sm && !(psw_wr && !wdata[`PSW_SM]));
  wire [6:0]  ridx       = addr[6:0];
  wire        row_acc    = wr && addr[`ROW_BIT];
  area_t      area;
  assign area = area_of(ridx);
  wire        row_we     = row_acc && (in_test || area == area_wo ||
                           (area == area_wp && !wp_lock));
  wire [7:0]  row_wval   = (in_test || area != area_wo) ? wdata :
                           (row_mem[ridx] | wdata);
  exc_code_t  exc_code;
  assign exc_code = fault_hit ? exc_fault : light_hit ? exc_ee_light :
                    (cur_idx == 2'h2) ? exc_stack_super :
                    (cur_idx == 2'h1) ? exc_stack_sys : exc_stack_user;
  cpu_mode_t  mode_now;
  assign mode_now = ssm ? (kind == kind_boot ? mode_boot :
                           kind == kind_test ? mode_test : mode_ctless) :
                    sm ? mode_system : mode_user;
  wire [7:0]  rd_val =
    addr[`ROW_BIT]         ? row_mem[ridx] :
    (addr == `REG_PSW)     ? {6'h0, ssm, sm} :
    (addr == `REG_CAUSE)   ? {2'h0, reset_cause} :
    (addr == `REG_EXC)     ? {5'h0, exc_reason} :
    (addr == `REG_LSEL)    ? {6'h0, light_sel} :
    (addr == `REG_HV)      ? {6'h0, hv_valid, hv_pass} :
    (addr == `REG_WPROT)   ? {7'h0, wp_lock} :
    (addr == `REG_LIM0)        ? lim[0] :
    (addr == `REG_LIM0 + 8'h1) ? lim[1] :
    (addr == `REG_LIM0 + 8'h2) ? lim[2] :
    (addr == `REG_SP)      ? sp[cur_idx] :
    (addr == `REG_FUSE)    ? {5'h0, test_fuse, fuse_deliv, fuse_aes} : 8'h00;

  // ************************************************
  // sensor inputs
  // ************************************************
  // three-stage synchroniser, second and third compared
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      s1 <= 4'h0;
      s2 <= 4'h0;
      s3 <= 4'h0;
    end else begin
      s1 <= sensor_pin;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // per-sensor level once stable
  for (genvar g = 0; g < 4; g++) begin : g_sens
    always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
        sens_q[g] <= 1'b0;
      end else if (s2[g] == s3[g]) begin
        sens_q[g] <= s3[g];
      end
    end
  end

  // ************************************************
  // forced reset and cause
  // ************************************************
  // counter survives its own reset, only reset_n clears it
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      force_cnt   <= 5'h0;
      force_reset <= 1'b0;
    end else begin
      force_cnt   <= next_force; // R1 R12
      force_reset <= (next_force != 5'h0); // R1 R12
    end
  end

  // cause outlives the forced reset it describes
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      reset_cause <= `CAUSE_EXT; // R4
    end else if (reset_fire) begin
      reset_cause <= {rom_parity_err, sens_q & {4{sensors_on}}, 1'b0}; // R4 R7
    end
  end

  // ************************************************
  // mode sequencer and flags
  // ************************************************
  // boot once, then test or run; never back to boot
  always_ff @(posedge clk_sys) begin
    if (rst_i) begin
      seq      <= seq_boot; // R3 R13 R16
      boot_cnt <= 3'h0;
      kind     <= kind_boot;
      ssm      <= 1'b1;
      sm       <= 1'b0;
    end else begin
      unique case (seq)
        seq_boot: begin
          boot_cnt <= boot_cnt + 3'h1;
          if (boot_cnt == 3'(`BOOT_CYC - 1)) begin
            if (test_avail) begin // R13 R14 R15
              seq  <= seq_test;
              kind <= kind_test;
            end else begin
              seq  <= seq_run;
              kind <= kind_ctless;
              ssm  <= 1'b0;
              sm   <= 1'b1;
            end
          end
        end
        seq_test: begin
          ssm <= next_ssm; // R24
          sm  <= next_sm;
          if (!next_ssm) begin // leaving test is final
            seq  <= seq_run;
            kind <= kind_ctless; // R14
          end
        end
        seq_run: begin
          ssm <= next_ssm; // R17 R24
          sm  <= next_sm; // R23 R24
        end
      endcase
    end
  end

  // ************************************************
  // exceptions
  // ************************************************
  // one pulse per event, reason held
  always_ff @(posedge clk_sys) begin
    if (rst_i) begin
      exc_req    <= 1'b0;
      exc_reason <= exc_none;
    end else begin
      exc_req <= exc_fire; // R2 R9 R25
      if (exc_fire) begin
        exc_reason <= exc_code; // R5 R7
      end
    end
  end

  // ************************************************
  // software registers
  // ************************************************
  // configuration, hv check, lock and fuse latch
  always_ff @(posedge clk_sys) begin
    if (rst_i) begin
      light_sel  <= 2'h0;
      hv_valid   <= 1'b0;
      hv_pass    <= 1'b0;
      wp_lock    <= 1'b0;
      fuse_aes   <= 1'b0;
      fuse_deliv <= 1'b1;
      test_fuse  <= 1'b0;
    end else begin
      if (wr && addr == `REG_LSEL) begin
        light_sel <= wdata[1:0]; // R8
      end
      if (ee_wr_seq) begin
        hv_valid <= 1'b1; // R10
        hv_pass  <= hv_ok;
      end
      if (wr && addr == `REG_WPROT && wdata[0]) begin
        wp_lock <= 1'b1; // R21
      end
      if (seq == seq_boot) begin
        fuse_aes   <= fuse_aes_en; // R18
        fuse_deliv <= fuse_delivered;
        test_fuse  <= test_req;
      end
    end
  end

  // per-mode stack pointers and limits
  for (genvar m = 0; m < 3; m++) begin : g_stack
    always_ff @(posedge clk_sys) begin
      if (rst_i) begin
        sp[m]  <= 8'h00;
        lim[m] <= `LIM_RST;
      end else begin
        if (sp_load && cur_idx == 2'(m)) begin
          sp[m] <= sp_value; // R9
        end
        if (wr && addr == `REG_LIM0 + 8'(m)) begin
          lim[m] <= wdata;
        end
      end
    end
  end

  // security row storage, non-volatile so not reset
  always_ff @(posedge clk_sys) begin
    if (row_we) begin
      row_mem[ridx] <= row_wval; // R19 R20 R21 R22
    end
  end

  // ************************************************
  // outputs
  // ************************************************
  // read data only in the cycle after the strobe
  always_ff @(posedge clk_sys) begin
    if (rst_i) begin
      rdata          <= 8'h00;
      cpu_mode       <= mode_boot;
      sensors_enable <= 1'b1;
      aes_enable     <= 1'b0;
      ee_data        <= 8'h00;
      ee_data_valid  <= 1'b0;
    end else begin
      rdata          <= rd ? rd_val : 8'h00;
      cpu_mode       <= mode_now; // R23
      sensors_enable <= sensors_on; // R6
      aes_enable     <= fuse_aes; // R18
      ee_data_valid  <= ee_code_valid;
      if (ee_code_valid) begin
        ee_data <= sec_fix(ee_code); // R11
      end
    end
  end

  // ************************************************
  // assertions
  // ************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst_i);

  sequence leave_boot;
    (seq == seq_boot) ##1 (seq != seq_boot);
  endsequence

  a_sensor_reset: assert property (disable iff (!reset_n) // R1
    (force_cnt == 5'h0 && |sens_q && seq != seq_test) |=> force_reset [*8])
    else $error("sensor alarm did not force reset");
  a_rom_reset: assert property (disable iff (!reset_n) // R12
    (force_cnt == 5'h0 && rom_parity_err) |=> force_reset && reset_cause[5])
    else $error("rom parity did not force reset");
  a_reset_state: assert property (disable iff (!reset_n) // R3
    force_reset |=> ssm && !sm && seq == seq_boot && exc_reason == exc_none)
    else $error("state not defaulted by forced reset");
  a_cause_kept: assert property (disable iff (!reset_n) // R4
    $rose(force_reset) |-> reset_cause != 6'h0 && !reset_cause[0])
    else $error("reset cause not recorded");
  a_fault_exc: assert property ( // R2
    (fault_hit && !reset_fire) |=> exc_req && exc_reason == exc_fault)
    else $error("fault did not raise exception");
  a_reset_wins: assert property (disable iff (!reset_n) // R25
    reset_fire |=> !exc_req)
    else $error("exception beside forced reset");
  a_stack_exc: assert property ( // R9
    (stack_hit && !fault_hit && !light_hit && !reset_fire) |=> exc_req &&
    exc_reason inside {exc_stack_user, exc_stack_sys, exc_stack_super})
    else $error("stack limit missed");
  a_flag_clear: assert property ( // R24
    (!cfg_call && seq == seq_run) |=> !$rose(ssm))
    else $error("super flag set by software");
  a_boot_once: assert property ( // R16
    (seq != seq_boot) |=> (seq != seq_boot))
    else $error("boot mode re-entered");
  a_test_gate: assert property ( // R15
    leave_boot |-> ((seq == seq_test) == $past(test_avail)))
    else $error("test entry decision wrong");
  a_ro_area: assert property ( // R20
    (row_acc && !in_test && area == area_ro) |-> !row_we)
    else $error("read-only row byte written");
  a_once_bits: assert property ( // R22
    (row_we && !in_test && area == area_wo) |->
    ((row_wval & row_mem[ridx]) == row_mem[ridx]))
    else $error("write-once bit cleared");
  a_sensors_on: assert property ( // R6
    (seq != seq_test) |=> sensors_enable)
    else $error("sensors disabled outside test");
endmodule

/* smfc_map.svh */
// constants of the security supervisor: register map, fields, timing
// assumes a 250 MHz system clock and an 8-bit register port
//
// Summary of operation
// R1: out-of-range sensors force a chip reset
// R2: eeprom light or fault detector raises exception
// R3: any reset returns all state to defaults; forced reset keeps reset_cause, no reset clears the row
// R4: reset cause kept readable after restart
// R5: exception reason recorded for software
// R6: sensors on outside test, never software-disabled
// R7: alarm-to-response mapping fixed in hardware
// R8: eeprom light detection: function a, b or off
// R9: per-mode stack pointer and limit exception
// R10: programming voltage check latched, no event
// R11: eeprom reads correct one bit per byte
// R12: rom parity mismatch forces chip reset
// R13: boot first, then test or system mode
// R14: boot may leave, nothing returns to boot
// R15: delivered chip never enters test mode
// R16: boot mode only right after reset
// R17: super flag later selects contactless mode only
// R18: fuse configuration immune to software
// R19: top 128 bytes form the security row
// R20: read-only area ignores software writes
// R21: protected area writable until locked
// R22: write-once area bits only set
// R23: two mode flags, both clear means user
// R24: software writes only clear mode flags
// R25: reset alarm beats same-cycle exception
`ifndef SMFC_MAP_SVH
`define SMFC_MAP_SVH
// ************************************************
// timing
// ************************************************
`define CLK_NS       4
`define FORCE_NS     64
`define FORCE_CYC    ((`FORCE_NS + `CLK_NS - 1) / `CLK_NS)
`define BOOT_NS      32
`define BOOT_CYC     ((`BOOT_NS + `CLK_NS - 1) / `CLK_NS)
// ************************************************
// register offsets
// ************************************************
`define REG_PSW      8'h00
`define REG_CAUSE    8'h01
`define REG_EXC      8'h02
`define REG_LSEL     8'h03
`define REG_HV       8'h04
`define REG_WPROT    8'h05
`define REG_LIM0     8'h06
`define REG_SP       8'h09
`define REG_FUSE     8'h0a
// ************************************************
// fields and reset values
// ************************************************
`define ROW_BIT      7
`define ROW_RO_END   7'h20
`define ROW_WP_END   7'h30
`define ROW_WO_END   7'h50
`define PSW_SSM      1
`define PSW_SM       0
`define CAUSE_EXT    6'h01
`define LSEL_A       2'h1
`define LSEL_B       2'h2
`define LIM_RST      8'hff
`endif

/* smfc_pkg.sv */
// types of the security supervisor
// assumes nothing beyond a SystemVerilog compiler
package smfc_pkg;
  typedef enum logic [1:0] {kind_boot, kind_test, kind_ctless} ssm_kind_t;
  typedef enum logic [1:0] {seq_boot, seq_test, seq_run} seq_t;
  typedef enum logic [2:0] {mode_boot, mode_test, mode_ctless, mode_system,
                            mode_user} cpu_mode_t;
  typedef enum logic [2:0] {exc_none, exc_ee_light, exc_fault, exc_stack_user,
                            exc_stack_sys, exc_stack_super} exc_code_t;
  typedef enum logic [1:0] {area_ro, area_wp, area_wo, area_cfg} area_t;
endpackage

/* cpu_model.sv */
// cpu core model: drives the register port and the mode call strobes
// assumes the supervisor samples every strobe on the rising clk_sys edge
`timescale 1ns/1ns
module cpu_model (
  input  wire logic       clk_sys,
  output logic      [7:0] addr,
  output logic      [7:0] wdata,
  output logic            wr,
  output logic            rd,
  input  wire logic [7:0] rdata,
  output logic            sp_load,
  output logic      [7:0] sp_value,
  output logic            sys_call,
  output logic            cfg_call
);
  // ************************************************
  // idle bus at time zero
  // ************************************************
  initial begin
    addr     = 8'h00;
    wdata    = 8'h00;
    wr       = 1'b0;
    rd       = 1'b0;
    sp_load  = 1'b0;
    sp_value = 8'h00;
    sys_call = 1'b0;
    cfg_call = 1'b0;
  end
  // ************************************************
  // bus cycles
  // ************************************************
  // one-cycle write; released address and data are inverted, not held
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk_sys);
    wr    <= 1'b0;
    addr  <= ~a;
    wdata <= ~d;
  endtask
  // one-cycle read; data taken in the cycle after the strobe only
  task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk_sys);
    rd   <= 1'b0;
    addr <= ~a;
    #1;
    d = rdata;
  endtask
  // one-cycle strobe: 0 stack load, 1 system call, 2 config call
  task automatic strobe(input int k, input logic [7:0] v);
    @(posedge clk_sys);
    sp_value <= v;
    sp_load  <= (k == 0);
    sys_call <= (k == 1);
    cfg_call <= (k == 2);
    @(posedge clk_sys);
    sp_load  <= 1'b0;
    sys_call <= 1'b0;
    cfg_call <= 1'b0;
  endtask
endmodule

/* secure_mode_fault_control_tb_top.sv */
// testbench of the security supervisor: one task per scenario
// assumes cpu_model and the design files are compiled before it
`timescale 1ns/1ns
module secure_mode_fault_control_tb_top;
  import smfc_pkg::*;
  // ************************************************
  // signals
  // ************************************************
  logic        clk_sys, reset_n, rom_parity_err, ee_light_a, ee_light_b, sp_load;
  logic        sys_call, cfg_call, ee_wr_seq, hv_ok, ee_code_valid, fuse_aes_en;
  logic        fuse_delivered, test_req, wr, rd, force_reset, exc_req;
  logic        sensors_enable, aes_enable, ee_data_valid;
  logic [3:0]  sensor_pin;
  logic [4:0]  fault_detect;
  logic [7:0]  sp_value, addr, wdata, rdata, ee_data, v;
  logic [11:0] ee_code, c;
  exc_code_t   exc_reason;
  cpu_mode_t   cpu_mode;
  int          fail_count, compares, n;
  // ************************************************
  // clock, partner and design
  // ************************************************
  always #2 clk_sys = ~clk_sys;
  cpu_model cpu (.clk_sys, .addr, .wdata, .wr, .rd, .rdata, .sp_load, .sp_value,
                 .sys_call, .cfg_call);
  secure_mode_fault_control #(.NFAULT(5)) dut (.clk_sys, .reset_n, .sensor_pin,
    .rom_parity_err, .fault_detect, .ee_light_a, .ee_light_b, .sp_load, .sp_value,
    .sys_call, .cfg_call, .ee_wr_seq, .hv_ok, .ee_code, .ee_code_valid, .fuse_aes_en,
    .fuse_delivered, .test_req, .addr, .wdata, .wr, .rd, .rdata, .force_reset,
    .exc_req, .exc_reason, .cpu_mode, .sensors_enable, .aes_enable, .ee_data,
    .ee_data_valid);
  // ************************************************
  // helpers
  // ************************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic settle;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask
  // reset held 8 cycles with given fuse levels, then boot phase passes
  task automatic do_reset(input logic tr, input logic dl, input logic ae);
    @(posedge clk_sys);
    test_req       <= tr;
    fuse_delivered <= dl;
    fuse_aes_en    <= ae;
    reset_n        <= 1'b0;
    repeat (8) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (12) @(posedge clk_sys);
    #1;
  endtask
  // one-cycle alarm: 0..4 fault bit, 5 light a, 6 light b
  task automatic hit(input int k, input logic exp, input exc_code_t r);
    @(posedge clk_sys);
    if (k < 5) fault_detect[k] <= 1'b1;
    else if (k == 5) ee_light_a <= 1'b1;
    else ee_light_b <= 1'b1;
    @(posedge clk_sys);
    fault_detect <= 5'h00;
    ee_light_a   <= 1'b0;
    ee_light_b   <= 1'b0;
    #1;
    chk(exc_req, exp);
    if (exp) chk(exc_reason, r);
  endtask
  // even-parity hamming codeword, parity at positions 1,2,4,8
  function automatic logic [11:0] enc(input logic [7:0] d);
    logic [11:0] w;
    w = {d[7:4], 1'b0, d[3:1], 1'b0, d[0], 2'b00};
    for (int p = 0; p < 4; p++)
      for (int j = 1; j <= 12; j++)
        if (j[p] && j != (1 << p)) w[(1 << p) - 1] ^= w[j - 1];
    return w;
  endfunction
  // ************************************************
  // scenarios
  // ************************************************
  // test mode: sensors off, row preload, fuses immune, row access kinds
  task automatic t_test_row;
    do_reset(1'b1, 1'b0, 1'b1);
    chk(cpu_mode, mode_test);
    chk(sensors_enable, 1'b0);
    @(posedge clk_sys);
    sensor_pin <= 4'h4;
    repeat (10) @(posedge clk_sys);
    sensor_pin <= 4'h0;
    #1;
    chk(force_reset, 1'b0);
    cpu.reg_wr(8'h80, 8'h11);
    cpu.reg_wr(8'ha0, 8'h22);
    cpu.reg_wr(8'hb0, 8'h0f);
    cpu.reg_wr(8'h0a, 8'h00);
    cpu.reg_rd(8'h0a, v);
    chk(v, 8'h05);
    chk(aes_enable, 1'b1);
    cpu.reg_wr(8'h00, 8'h00);
    cpu.reg_wr(8'h80, 8'hff);
    cpu.reg_rd(8'h80, v);
    chk(v, 8'h11);
    cpu.reg_wr(8'ha0, 8'h33);
    cpu.reg_rd(8'ha0, v);
    chk(v, 8'h33);
    cpu.reg_wr(8'h05, 8'h01);
    cpu.reg_wr(8'ha0, 8'h44);
    cpu.reg_rd(8'ha0, v);
    chk(v, 8'h33);
    cpu.reg_wr(8'hb0, 8'hf0);
    cpu.reg_rd(8'hb0, v);
    chk(v, 8'hff);
    cpu.reg_wr(8'hb0, 8'h00);
    cpu.reg_rd(8'hb0, v);
    chk(v, 8'hff);
    $display("test row and test mode done");
  endtask
  // delivered chip: boot to system, reset values, refused accesses
  task automatic t_boot;
    do_reset(1'b1, 1'b1, 1'b0);
    chk(cpu_mode, mode_system);
    chk(sensors_enable, 1'b1);
    chk(aes_enable, 1'b0);
    cpu.reg_wr(8'h01, 8'hff);
    cpu.reg_rd(8'h01, v);
    chk(v, 8'h01);
    cpu.reg_rd(8'h02, v);
    chk(v, 8'h00);
    for (int a = 6; a < 9; a++) begin
      cpu.reg_rd(a[7:0], v);
      chk(v, 8'hff);
    end
    cpu.reg_rd(8'h0f, v);
    chk(v, 8'h00);
    $display("test boot done");
  endtask
  // mode flags: clear only by write, set by calls, contactless on super
  task automatic t_modes;
    cpu.reg_wr(8'h00, 8'h03);
    cpu.reg_rd(8'h00, v);
    chk(v, 8'h01);
    cpu.reg_wr(8'h00, 8'h00);
    settle;
    chk(cpu_mode, mode_user);
    cpu.reg_wr(8'h00, 8'h03);
    cpu.reg_rd(8'h00, v);
    chk(v, 8'h00);
    cpu.strobe(1, 8'h00);
    settle;
    chk(cpu_mode, mode_system);
    cpu.strobe(2, 8'h00);
    settle;
    chk(cpu_mode, mode_ctless);
    cpu.reg_wr(8'h00, 8'h00);
    settle;
    chk(cpu_mode, mode_user);
    $display("test modes done");
  endtask
  // user stack limit, then fault bits and light selection
  task automatic t_alarms;
    cpu.reg_wr(8'h06, 8'h10);
    cpu.strobe(0, 8'h0f);
    #1;
    chk(exc_req, 1'b0);
    cpu.strobe(0, 8'h10);
    #1;
    chk(exc_req, 1'b1);
    chk(exc_reason, exc_stack_user);
    // now in system mode: its own limit applies, not the user one
    cpu.strobe(0, 8'h20);
    #1;
    chk(exc_req, 1'b0);
    cpu.reg_wr(8'h07, 8'h20);
    cpu.strobe(0, 8'h20);
    #1;
    chk(exc_reason, exc_stack_sys);
    for (int k = 0; k < 5; k++) hit(k, 1'b1, exc_fault);
    cpu.reg_rd(8'h02, v);
    chk(v, 8'h02);
    for (int s = 0; s < 4; s++) begin
      cpu.reg_wr(8'h03, s[7:0]);
      hit(5, s == 1, exc_ee_light);
      hit(6, s == 2, exc_ee_light);
    end
    $display("test alarms done");
  endtask
  // voltage check latched without events; ecc fixes any single bit
  task automatic t_hv_ecc;
    for (int h = 0; h < 2; h++) begin
      @(posedge clk_sys);
      hv_ok     <= h[0];
      ee_wr_seq <= 1'b1;
      @(posedge clk_sys);
      ee_wr_seq <= 1'b0;
      #1;
      chk(exc_req | force_reset, 1'b0);
      cpu.reg_rd(8'h04, v);
      chk(v, {6'h00, 1'b1, h[0]});
    end
    for (int f = -1; f < 12; f++) begin
      c = enc(8'ha5);
      if (f >= 0) c[f] = ~c[f];
      @(posedge clk_sys);
      ee_code       <= c;
      ee_code_valid <= 1'b1;
      @(posedge clk_sys);
      ee_code_valid <= 1'b0;
      #1;
      chk(ee_data_valid, 1'b1);
      chk(ee_data, 8'ha5);
    end
    $display("test voltage and ecc done");
  endtask
  // each reset source, then reset beating a same-cycle exception
  task automatic t_force;
    for (int k = 0; k < 5; k++) begin
      @(posedge clk_sys);
      if (k < 4) sensor_pin[k] <= 1'b1;
      else rom_parity_err <= 1'b1;
      n = 0;
      while (force_reset !== 1'b1 && n < 8) begin
        @(posedge clk_sys);
        #1;
        n++;
      end
      // state falls back one cycle after force_reset rises
      @(posedge clk_sys);
      #1;
      chk(cpu_mode, mode_boot);
      n = 1;
      while (force_reset === 1'b1 && n < 40) begin
        n++;
        @(posedge clk_sys);
        sensor_pin     <= 4'h0;
        rom_parity_err <= 1'b0;
        #1;
      end
      chk(n, 16);
      repeat (12) @(posedge clk_sys);
      cpu.reg_rd(8'h01, v);
      chk(v, 8'h01 << (k + 1));
      chk(cpu_mode, mode_system);
    end
    @(posedge clk_sys);
    fault_detect   <= 5'h01;
    rom_parity_err <= 1'b1;
    @(posedge clk_sys);
    fault_detect   <= 5'h00;
    rom_parity_err <= 1'b0;
    #1;
    chk({force_reset, exc_req}, 8'h02);
    repeat (30) @(posedge clk_sys);
    cpu.reg_rd(8'h02, v);
    chk(v, 8'h00);
    $display("test forced reset done");
  endtask
  // ************************************************
  // main sequence and watchdog
  // ************************************************
  initial begin
    clk_sys        = 1'b0;
    reset_n        = 1'b0;
    sensor_pin     = 4'h0;
    rom_parity_err = 1'b0;
    fault_detect   = 5'h00;
    ee_light_a     = 1'b0;
    ee_light_b     = 1'b0;
    ee_wr_seq      = 1'b0;
    hv_ok          = 1'b0;
    ee_code        = 12'h000;
    ee_code_valid  = 1'b0;
    fuse_aes_en    = 1'b0;
    fuse_delivered = 1'b1;
    test_req       = 1'b0;
    fail_count     = 0;
    compares       = 0;
    t_test_row;
    t_boot;
    t_modes;
    t_alarms;
    t_hv_ecc;
    t_force;
    end_sim;
  end
  initial begin
    #100000;
    fail_count++;
    end_sim;
  end
endmodule
